// ### logic/ccr_top.sv
`timescale 1ns/100ps
module ccr_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 4
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + CW'(push) - CW'(pop);
        end
    end
endmodule

module ccr_top
    import ccr_pkg::*;
#(
    parameter int BIT_CYCLES = CC_BIT_CYCLES,
    parameter int SRST_LEN   = SRST_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    input  wire logic        line_start,
    input  wire logic [9:0]  line_number,
    input  wire logic        odd_field,
    input  wire logic [1:0]  video_std,
    input  wire logic [7:0]  even_caption_second_byte,
    input  wire logic        cc_sink_ready,
    output logic             cc_valid,
    output logic             cc_data,
    output logic             cc_field_even,
    output logic             power_down,
    output logic      [3:0]  dac_disable
);
    localparam int SRST_MAX = 40;
    logic [1:0]       cle;
    logic [7:0]       odd_caption_first_byte;
    logic [7:0]       odd_caption_second_byte;
    logic [7:0]       even_caption_first_byte;
    logic             odd_st;
    logic             even_st;
    logic             srst_busy;
    logic [7:0]       srst_cnt;
    logic             setup;
    logic             wr;
    logic [7:0]       widx;
    logic [7:0]       ridx;
    logic [7:0]       host_rd;
    logic [9:0]       odd_line;
    logic [9:0]       even_line;
    logic             want_odd;
    logic             want_even;
    logic             push;
    logic             push_ready;
    logic [16:0]      push_data;
    logic             pop;
    logic             fifo_valid;
    logic [16:0]      fifo_data;
    ccr_state_e       state;
    logic [15:0]      shreg;
    logic [3:0]       bitn;
    logic [9:0]       div;
    logic             done;

    assign setup   = psel && !penable;
    assign wr      = psel && penable && pready && pwrite && !srst_busy && paddr[1:0] == 2'h0;
    assign widx    = {2'h0, paddr[7:2]};
    assign ridx    = {2'h0, paddr[7:2]};
    assign host_rd = {srst_busy, power_down, dac_disable[3], odd_st, even_st, dac_disable[2:0]};

    // apb answer one cycle after setup, bad address flagged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            if (setup) begin
                pslverr <= (paddr[9:8] != 2'h0) || paddr[1:0] != 2'h0 ||
                           !(ridx inside {IDX_CLE, IDX_HOST, IDX_ODD_FIRST, IDX_ODD_SEC, IDX_EVEN_FIRST});
                if (!pwrite && paddr[9:8] == 2'h0) begin
                    unique case (ridx)
                        IDX_CLE:        prdata <= {24'h0, cle, 6'h0};
                        IDX_HOST:       prdata <= {24'h0, host_rd};
                        IDX_ODD_FIRST:  prdata <= {24'h0, odd_caption_first_byte};
                        IDX_ODD_SEC:    prdata <= {24'h0, odd_caption_second_byte};
                        IDX_EVEN_FIRST: prdata <= {24'h0, even_caption_first_byte};
                        default:        prdata <= 32'h0;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            srst_busy <= 1'b0;
            srst_cnt  <= 8'h0;
        end else if (srst_busy) begin
            srst_cnt <= srst_cnt + 8'h1;
            if (srst_cnt == 8'(SRST_LEN - 1)) begin
                srst_busy <= 1'b0;
            end
        end else if (wr && paddr[9:8] == 2'h0 && widx == IDX_HOST && pwdata[HC_SRST]) begin
            srst_busy <= 1'b1;
            srst_cnt  <= 8'h0;
        end
    end

    // writable fields, held at reset values while soft reset runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cle                     <= CLE_RST;
            power_down              <= 1'b0;
            dac_disable             <= 4'h0;
            odd_caption_first_byte  <= CAP_RST;
            odd_caption_second_byte <= CAP_RST;
            even_caption_first_byte <= CAP_RST;
        end else if (srst_busy) begin
            cle                     <= CLE_RST;
            power_down              <= 1'b0;
            dac_disable             <= 4'h0;
            odd_caption_first_byte  <= CAP_RST;
            odd_caption_second_byte <= CAP_RST;
            even_caption_first_byte <= CAP_RST;
        end else if (wr && paddr[9:8] == 2'h0) begin
            unique case (widx)
                IDX_CLE:        cle <= pwdata[CLE_LSB+1:CLE_LSB];
                IDX_HOST: begin
                    power_down  <= pwdata[HC_PDN];
                    dac_disable <= {pwdata[HC_DIS_CMP2], pwdata[HC_DIS_CMP1], pwdata[HC_DIS_LUMA],
                                    pwdata[HC_DIS_CHR]};
                end
                IDX_ODD_FIRST:  odd_caption_first_byte  <= pwdata[7:0];
                IDX_ODD_SEC:    odd_caption_second_byte <= pwdata[7:0];
                IDX_EVEN_FIRST: even_caption_first_byte <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // status flags, end of transmission wins over a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            odd_st  <= 1'b1;
            even_st <= 1'b1;
        end else if (srst_busy) begin
            odd_st  <= 1'b1;
            even_st <= 1'b1;
        end else begin
            if (done && !cc_field_even) begin
                odd_st <= 1'b1;
            end else if (wr && paddr[9:8] == 2'h0 && (widx == IDX_ODD_FIRST || widx == IDX_ODD_SEC)) begin
                odd_st <= 1'b0;
            end
            if (done && cc_field_even) begin
                even_st <= 1'b1;
            end else if (wr && paddr[9:8] == 2'h0 && widx == IDX_EVEN_FIRST) begin
                even_st <= 1'b0;
            end
        end
    end

    always_comb begin
        unique case (video_std)
            CCR_STD_NTSC: begin
                odd_line  = LINE_ODD_NTSC;
                even_line = LINE_EVEN_NTSC;
            end
            CCR_STD_MPAL: begin
                odd_line  = LINE_ODD_MPAL;
                even_line = LINE_EVEN_MPAL;
            end
            default: begin
                odd_line  = LINE_ODD_PAL;
                even_line = LINE_EVEN_PAL;
            end
        endcase
    end

    assign want_odd  = line_start && odd_field && cle[0] && line_number == odd_line;
    assign want_even = line_start && !odd_field && cle[1] && line_number == even_line;
    // a full queue drops this field's slot rather than stalling video timing
    assign push      = (want_odd || want_even) && !power_down && !srst_busy && push_ready;
    // first byte in the low half goes out first
    assign push_data = want_even ? {1'b1, even_caption_second_byte, even_caption_first_byte}
                                 : {1'b0, odd_caption_second_byte, odd_caption_first_byte};
    assign pop       = (state == CCR_IDLE) && fifo_valid && cc_sink_ready && !srst_busy;

    ccr_fifo #(
        .WIDTH (17),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (push),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_data)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state         <= CCR_IDLE;
            shreg         <= 16'h0;
            bitn          <= 4'h0;
            div           <= 10'h0;
            cc_valid      <= 1'b0;
            cc_data       <= 1'b0;
            cc_field_even <= 1'b0;
            done          <= 1'b0;
        end else if (srst_busy) begin
            state    <= CCR_IDLE;
            cc_valid <= 1'b0;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state)
                CCR_IDLE: begin
                    if (pop) begin
                        shreg         <= fifo_data[15:0];
                        cc_field_even <= fifo_data[16];
                        cc_data       <= fifo_data[0];
                        cc_valid      <= 1'b1;
                        bitn          <= 4'h0;
                        div           <= 10'h0;
                        state         <= CCR_SHIFT;
                    end
                end
                CCR_SHIFT: begin
                    if (div == 10'(BIT_CYCLES - 1)) begin
                        div <= 10'h0;
                        if (bitn == 4'(CC_WORD_BITS - 1)) begin
                            cc_valid <= 1'b0;
                            done     <= 1'b1;
                            state    <= CCR_IDLE;
                        end else begin
                            bitn    <= bitn + 4'h1;
                            shreg   <= {1'b0, shreg[15:1]};
                            cc_data <= shreg[1];
                        end
                    end else begin
                        div <= div + 10'h1;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_off_no_insert;
        cle == 2'h0 |-> !push;
    endproperty
    a_off_no_insert: assert property (p_off_no_insert) else $error("caption queued while disabled");

    property p_odd_line;
        push && !push_data[16] |-> cle[0] && odd_field && line_number == odd_line;
    endproperty
    a_odd_line: assert property (p_odd_line) else $error("odd caption on wrong line");

    property p_even_line;
        push && push_data[16] |-> cle[1] && !odd_field && line_number == even_line;
    endproperty
    a_even_line: assert property (p_even_line) else $error("even caption on wrong line");

    property p_both_fields;
        cle == 2'h3 && line_start && !power_down && !srst_busy && push_ready &&
            (odd_field ? line_number == odd_line : line_number == even_line) |-> push && push_data[16] == !odd_field;
    endproperty
    a_both_fields: assert property (p_both_fields) else $error("caption slot missed");

    property p_srst_clears;
        $rose(srst_busy) |-> ##[1:SRST_MAX] !srst_busy;
    endproperty
    a_srst_clears: assert property (p_srst_clears) else $error("soft reset never ends");

    property p_srst_values;
        $fell(srst_busy) |-> cle == CLE_RST && odd_st && even_st && dac_disable == 4'h0 && !power_down;
    endproperty
    a_srst_values: assert property (p_srst_values) else $error("soft reset left state");

    property p_pdn_quiet;
        power_down |-> !push;
    endproperty
    a_pdn_quiet: assert property (p_pdn_quiet) else $error("caption queued in power down");

    property p_dac_write;
        wr && paddr[9:8] == 2'h0 && widx == IDX_HOST |=>
            dac_disable == {$past(pwdata[5]), $past(pwdata[2:0])} && power_down == $past(pwdata[6]);
    endproperty
    a_dac_write: assert property (p_dac_write) else $error("host control not applied");

    property p_odd_flag;
        wr && paddr[9:8] == 2'h0 && widx == IDX_ODD_FIRST && !done |=> !odd_st;
    endproperty
    a_odd_flag: assert property (p_odd_flag) else $error("odd flag not cleared");

    property p_even_done;
        done && cc_field_even |=> even_st;
    endproperty
    a_even_done: assert property (p_even_done) else $error("even flag not set");

    property p_first_bit;
        pop |=> cc_valid && cc_data == $past(fifo_data[0]) && cc_field_even == $past(fifo_data[16]);
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("wrong first caption bit");

    property p_shift_order;
        state == CCR_SHIFT && !srst_busy && div == 10'(BIT_CYCLES - 1) && bitn != 4'hf |=>
            cc_data == $past(shreg[1]);
    endproperty
    a_shift_order: assert property (p_shift_order) else $error("caption bit order broken");

    property p_word_len;
        pop |=> cc_valid [*8];
    endproperty
    a_word_len: assert property (p_word_len) else $error("caption word cut short");

    c_odd_sent:  cover property (done && !cc_field_even);
    c_even_sent: cover property (done && cc_field_even);
    c_srst:      cover property ($fell(srst_busy));
    c_full:      cover property (!push_ready);
endmodule

// ### logic/ccr_pkg.sv
package ccr_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CLE       = 8'h06;
    localparam logic [7:0] IDX_HOST      = 8'h0f;
    localparam logic [7:0] IDX_ODD_FIRST = 8'h10;
    localparam logic [7:0] IDX_ODD_SEC   = 8'h11;
    localparam logic [7:0] IDX_EVEN_FIRST= 8'h12;
    // field positions
    localparam int CLE_LSB    = 6;
    localparam int HC_SRST    = 7;
    localparam int HC_PDN     = 6;
    localparam int HC_DIS_CMP2= 5;
    localparam int HC_ODD_ST  = 4;
    localparam int HC_EVEN_ST = 3;
    localparam int HC_DIS_CMP1= 2;
    localparam int HC_DIS_LUMA= 1;
    localparam int HC_DIS_CHR = 0;
    // reset values
    localparam logic [1:0] CLE_RST = 2'h0;
    localparam logic [7:0] CAP_RST = 8'h80;
    // caption lines per standard
    localparam logic [9:0] LINE_ODD_NTSC  = 10'h015;
    localparam logic [9:0] LINE_ODD_MPAL  = 10'h012;
    localparam logic [9:0] LINE_ODD_PAL   = 10'h016;
    localparam logic [9:0] LINE_EVEN_NTSC = 10'h11c;
    localparam logic [9:0] LINE_EVEN_MPAL = 10'h119;
    localparam logic [9:0] LINE_EVEN_PAL  = 10'h14f;
    // timing counts
    localparam int CC_WORD_BITS  = 16;
    localparam int CC_BIT_CYCLES = 497;
    localparam int SRST_CYCLES   = 16;
    localparam int FIFO_DEPTH    = 4;
    typedef enum logic [1:0] {
        CCR_STD_NTSC = 2'h0,
        CCR_STD_MPAL = 2'h1,
        CCR_STD_PAL  = 2'h2
    } ccr_std_e;
    typedef enum logic [1:0] {
        CCR_IDLE  = 2'h1,
        CCR_SHIFT = 2'h2
    } ccr_state_e;
endpackage

// ### bench/ccr_host.sv
`timescale 1ns/100ps
module ccr_host
    import ccr_pkg::*;
(
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [9:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 10'h000;
        pwdata  = 32'h0;
    end
    // request held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // released data is scrambled so a stale word never looks valid
        pwdata  <= ~d;
    endtask
    task automatic wait_flag(input int bitpos);
        logic [31:0] rd;
        logic        e;
        do xfer(1'b0, {IDX_HOST, 2'b00}, 32'h0, rd, e); while (rd[bitpos] !== 1'b1);
    endtask
endmodule

// ### bench/tb_caption_and_host_control_regs.sv
`timescale 1ns/100ps
module tb_caption_and_host_control_regs
    import ccr_pkg::*;
;
    localparam int BITC = 4;
    localparam int SRL  = 2;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, line_start, odd_field;
    logic        cc_sink_ready, cc_valid, cc_data, cc_field_even, power_down, fld, e;
    logic [9:0]  paddr, line_number;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  video_std;
    logic [7:0]  even_caption_second_byte, ob1, ob2, eb1;
    logic [3:0]  dac_disable;
    logic [15:0] shreg;
    logic [16:0] exp_q[$];
    int          err_total, check_count, cyc, cnt, cle, hc, odd_f, even_f, std;
    bit          stall, abort_ok;

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    ccr_top #(.BIT_CYCLES(BITC), .SRST_LEN(SRL)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .line_start(line_start), .line_number(line_number), .odd_field(odd_field),
        .video_std(video_std), .even_caption_second_byte(even_caption_second_byte),
        .cc_sink_ready(cc_sink_ready), .cc_valid(cc_valid), .cc_data(cc_data),
        .cc_field_even(cc_field_even), .power_down(power_down), .dac_disable(dac_disable));

    ccr_host host (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        check_count++;
        if (g !== ex) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, g);
        end
    endtask
    task automatic chk_word(input logic [16:0] ex, input logic [16:0] g);
        check_count++;
        if (g !== ex) begin
            err_total++;
            $display("MISMATCH caption_word expected %h seen %h", ex, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // hang guard, well above the few thousand cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            finish_test();
        end
    end
    // far side stalls at random unless held off
    always @(posedge pclk) cc_sink_ready <= stall ? 1'b0 : 1'($urandom % 2);

    // serial capture, sampled mid bit
    always @(posedge pclk) begin
        if (cc_valid === 1'b1) begin
            if (cnt == 0) fld = cc_field_even;
            if (cnt % BITC == 1 && cnt < 64) shreg[cnt / BITC] = cc_data;
            cnt++;
        end else if (cnt > 0) begin
            if (!abort_ok) chk("word_cycles", CC_WORD_BITS * BITC, cnt);
            if (cnt == CC_WORD_BITS * BITC) begin
                if (exp_q.size() == 0) chk("unexpected_word", 0, 1);
                else chk_word(exp_q.pop_front(), {fld, shreg});
                if (fld) even_f = 1;
                else odd_f = 1;
            end
            cnt = 0;
        end
    end

    function automatic logic [9:0] cap_line(int s, bit even);
        case (s)
            0: return even ? LINE_EVEN_NTSC : LINE_ODD_NTSC;
            1: return even ? LINE_EVEN_MPAL : LINE_ODD_MPAL;
            default: return even ? LINE_EVEN_PAL : LINE_ODD_PAL;
        endcase
    endfunction
    function automatic logic [31:0] hreg();
        return hc | (odd_f << HC_ODD_ST) | (even_f << HC_EVEN_ST);
    endfunction

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        host.xfer(1'b1, {idx, 2'b00}, d, rd, e);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] ex);
        host.xfer(1'b0, {idx, 2'b00}, 32'h0, rd, e);
        chk(nm, ex, rd);
    endtask
    task automatic check_all();
        rdchk("cle", IDX_CLE, cle << CLE_LSB);
        rdchk("host", IDX_HOST, hreg());
        rdchk("odd_first", IDX_ODD_FIRST, ob1);
        rdchk("odd_second", IDX_ODD_SEC, ob2);
        rdchk("even_first", IDX_EVEN_FIRST, eb1);
        chk("power_down", hc[HC_PDN], power_down);
        chk("dac_disable", {hc[5], hc[2], hc[1], hc[0]}, dac_disable);
    endtask
    // video timing marks one line; model queues the word it should produce
    task automatic vline(input logic [9:0] n, input logic odd, input bit hit);
        @(posedge pclk);
        line_start  <= 1'b1;
        line_number <= n;
        odd_field   <= odd;
        @(posedge pclk);
        line_start  <= 1'b0;
        line_number <= ~n;
        if (hit && !(stall && exp_q.size() >= FIFO_DEPTH))
            exp_q.push_back(odd ? {1'b0, ob2, ob1} : {1'b1, even_caption_second_byte, eb1});
    endtask
    task automatic drain();
        for (int i = 0; i < 800 && (exp_q.size() > 0 || cnt > 0); i++) @(posedge pclk);
        chk("pending_words", 0, exp_q.size());
    endtask
    task automatic model_reset();
        cle = 0;
        hc = 0;
        odd_f = 1;
        even_f = 1;
        ob1 = CAP_RST;
        ob2 = CAP_RST;
        eb1 = CAP_RST;
    endtask

    initial begin
        void'($urandom(12));
        presetn = 1'b0;
        line_start = 1'b0;
        line_number = 10'h000;
        odd_field = 1'b0;
        video_std = 2'h0;
        even_caption_second_byte = 8'h80;
        model_reset();
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check_all();
        host.xfer(1'b0, 10'h000, 32'h0, rd, e);
        chk("unmapped_err", 1, e);
        host.xfer(1'b1, 10'h03d, 32'h40, rd, e);
        chk("misaligned_err", 1, e);
        rdchk("host_after_bad_write", IDX_HOST, hreg());
        repeat (4) begin
            rd = $urandom & 32'h7f;
            hc = rd & 32'h67;
            wr(IDX_HOST, rd);
            check_all();
        end
        hc = 0;
        wr(IDX_HOST, 0);
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 4; c++) begin
                std = s;
                cle = c;
                video_std <= 2'(s);
                even_caption_second_byte <= 8'($urandom);
                wr(IDX_CLE, cle << CLE_LSB);
                if (odd_f == 1) begin
                    host.wait_flag(HC_ODD_ST);
                    ob1 = 8'($urandom);
                    ob2 = 8'($urandom);
                    wr(IDX_ODD_FIRST, ob1);
                    wr(IDX_ODD_SEC, ob2);
                    odd_f = 0;
                end
                if (even_f == 1) begin
                    host.wait_flag(HC_EVEN_ST);
                    eb1 = 8'($urandom);
                    wr(IDX_EVEN_FIRST, eb1);
                    even_f = 0;
                end
                rdchk("flags_after_write", IDX_HOST, hreg());
                vline(cap_line(s, 0) + 10'h001, 1'b1, 0);
                vline(cap_line(s, 1), 1'b1, 0);
                vline(cap_line(s, 0), 1'b1, c[0]);
                vline(cap_line(s, 1), 1'b0, c[1]);
                drain();
                check_all();
            end
        end
        // power down suppresses insertion
        hc = 32'h40;
        wr(IDX_HOST, hc);
        vline(cap_line(std, 0), 1'b1, 0);
        vline(cap_line(std, 1), 1'b0, 0);
        drain();
        hc = 0;
        wr(IDX_HOST, 0);
        // far side held off: queue fills to its depth, then drops
        stall = 1'b1;
        repeat (2) @(posedge pclk);
        repeat (3) begin
            vline(cap_line(std, 0), 1'b1, 1);
            vline(cap_line(std, 1), 1'b0, 1);
        end
        stall = 1'b0;
        drain();
        // soft reset in the middle of a word
        hc = 32'h25;
        wr(IDX_HOST, hc);
        vline(cap_line(std, 0), 1'b1, 1);
        for (int i = 0; i < 400 && cnt < 10; i++) @(posedge pclk);
        abort_ok = 1'b1;
        wr(IDX_HOST, 32'h80 | hc);
        model_reset();
        exp_q.delete();
        repeat (SRL + 4) @(posedge pclk);
        chk("valid_after_soft_reset", 0, cc_valid);
        check_all();
        abort_ok = 1'b0;
        finish_test();
    end
endmodule
